// File: afs_spi_cal.sv
`timescale 1ns/100ps
module afs_spi_cal import afs_pkg::*; (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_sck,
    input wire logic i_sdi,
    input wire logic i_chip_select_low_n,
    output logic o_serial_out_ready_pin,
    output logic o_serial_out_ready_pin_oe_n,
    input wire logic i_sample_valid,
    input wire logic [WORD_W-1:0] i_sample,
    output logic o_sample_ready,
    output logic [3:0] o_pos_channel_select,
    output logic [3:0] o_neg_channel_select,
    output logic o_ref_int_en,
    output logic o_first_amp_enable,
    output logic [2:0] o_second_amp_gain,
    output logic [3:0] o_mode,
    output logic o_conversion_ready_low,
    output logic [RES_W-1:0] o_conversion_result
);
    logic [2:0] sck_sync_reg;
    logic [1:0] cs_sync_reg;
    logic [1:0] sdi_sync_reg;
    logic sck_rise, sck_fall, cs_high, sdi_s;
    logic [3:0] mode_reg, psel_reg, nsel_reg;
    logic [7:0] option_reg;
    logic [WORD_W-1:0] offset_reg, gain_reg;
    logic [RES_W-1:0] result_reg;
    logic ready_low_reg, ov_reg;
    logic [1:0] rdy_cnt_reg;
    afs_phase_type phase_reg;
    logic [2:0] bit_cnt_reg;
    logic [6:0] rx_sh_reg;
    logic [7:0] tx_sh_reg;
    logic busy_reg, rw_reg, sdo_reg;
    logic [3:0] addr_reg;
    logic [1:0] left_reg;
    logic [WORD_W-1:0] data_reg;
    logic [7:0] rx_byte, tx_byte, status_byte;
    logic byte_done, wr_commit;
    logic [WORD_W-1:0] wr_word, rd_word, rd_aligned;
    logic [1:0] cmd_len;
    afs_seq_type seq_reg;
    logic [CNT_W-1:0] cnt_reg, conv_target;
    logic [WORD_W-1:0] meas_reg;
    logic [WORD_W:0] rem_reg, div_trial, rem_next;
    logic [DIV_BITS-1:0] quo_reg, quo_next;
    logic div_ge, is_cal, is_conv, conv_start;
    logic off_store, gain_store, conv_store;
    logic [WORD_W-1:0] gain_next;
    logic signed [WORD_W:0] diff;
    logic signed [2*WORD_W+1:0] prod;
    logic signed [2*WORD_W+1:0] scaled;
    logic [RES_W-1:0] result_next;
    logic ov_next;

    afs_stream_if #(.W(WORD_W)) wr_if ();
    afs_stream_if #(.W(WORD_W)) rd_if ();

    assign wr_if.valid = i_sample_valid;
    assign wr_if.data = i_sample;
    assign o_sample_ready = wr_if.ready;

    afs_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_wr(wr_if),
        .o_rd(rd_if)
    );

    // Pins cross into the clock domain; edges found past stage two
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            sck_sync_reg <= 3'h0;
            cs_sync_reg <= 2'h3;
            sdi_sync_reg <= 2'h0;
        end else begin
            sck_sync_reg <= {sck_sync_reg[1:0], i_sck};
            cs_sync_reg <= {cs_sync_reg[0], i_chip_select_low_n};
            sdi_sync_reg <= {sdi_sync_reg[0], i_sdi};
        end
    end

    assign cs_high = cs_sync_reg[1];
    assign sdi_s = sdi_sync_reg[1];
    assign sck_rise = sck_sync_reg[1] && !sck_sync_reg[2] && !cs_high;
    assign sck_fall = !sck_sync_reg[1] && sck_sync_reg[2] && !cs_high;

    assign rx_byte = {rx_sh_reg, sdi_s};
    assign byte_done = sck_fall && bit_cnt_reg == 3'h7;
    assign cmd_len = afs_reg_len(rx_byte[7:CMD_ADDR_LSB]);
    assign wr_word = {data_reg[15:0], rx_byte};
    assign wr_commit = byte_done && phase_reg == PH_DATA && !rw_reg
        && left_reg == 2'h1;
    assign status_byte = {3'h0, option_reg[OPT_CE_BIT], rdy_cnt_reg,
        ready_low_reg, ov_reg};
    assign tx_byte = (phase_reg == PH_CMD) ? status_byte : data_reg[23:16];

    always_comb begin
        case (rx_byte[7:CMD_ADDR_LSB])
            ADDR_CTRL: rd_word = {8'h00, mode_reg, psel_reg, nsel_reg,
                rdy_cnt_reg, ready_low_reg, ov_reg};
            ADDR_RESULT: rd_word = {8'h00, result_reg};
            ADDR_OPTION: rd_word = {16'h0000, option_reg};
            ADDR_OFF_HI: rd_word = {16'h0000, offset_reg[23:16]};
            ADDR_OFF_LO: rd_word = {8'h00, offset_reg[15:0]};
            ADDR_GAIN_HI: rd_word = {16'h0000, gain_reg[23:16]};
            ADDR_GAIN_LO: rd_word = {8'h00, gain_reg[15:0]};
            default: rd_word = 24'h000000;
        endcase
        case (cmd_len)
            2'h1: rd_aligned = {rd_word[7:0], 16'h0000};
            2'h2: rd_aligned = {rd_word[15:0], 8'h00};
            default: rd_aligned = rd_word;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst || cs_high) begin
            bit_cnt_reg <= 3'h0;
            rx_sh_reg <= 7'h00;
        end else if (sck_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            rx_sh_reg <= rx_byte[6:0];
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            sdo_reg <= 1'b0;
            tx_sh_reg <= 8'h00;
        end else if (sck_rise) begin
            if (bit_cnt_reg == 3'h0) begin
                sdo_reg <= tx_byte[7];
                tx_sh_reg <= {tx_byte[6:0], 1'b0};
            end else begin
                sdo_reg <= tx_sh_reg[7];
                tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
            end
        end
    end

    // byte framing alone when tied low
    always_ff @(posedge i_mclk) begin
        if (i_srst || cs_high) begin
            phase_reg <= PH_CMD;
            busy_reg <= 1'b0;
            addr_reg <= 4'h0;
            rw_reg <= 1'b0;
            left_reg <= 2'h0;
            data_reg <= '0;
        end else begin
            if (sck_rise) begin
                busy_reg <= 1'b1;
            end
            if (byte_done) begin
                if (phase_reg == PH_CMD) begin
                    addr_reg <= rx_byte[7:CMD_ADDR_LSB];
                    rw_reg <= rx_byte[CMD_RW_BIT];
                    left_reg <= cmd_len;
                    data_reg <= rd_aligned;
                    phase_reg <= PH_DATA;
                end else begin
                    data_reg <= wr_word;
                    left_reg <= left_reg - 2'h1;
                    if (left_reg == 2'h1) begin
                        phase_reg <= PH_CMD;
                        busy_reg <= 1'b0;
                    end
                end
            end
        end
    end

    assign o_serial_out_ready_pin = busy_reg ? sdo_reg : ready_low_reg;
    assign o_serial_out_ready_pin_oe_n = cs_high;

    assign is_cal = mode_reg == MODE_OFF_CAL || mode_reg == MODE_GAIN_CAL;
    assign is_conv = mode_reg != MODE_IDLE && mode_reg <= MODE_CONV_MAX;
    assign conv_target = (mode_reg == MODE_OFF_CAL)
        ? CNT_W'(OFF_CONV_CYC) : CNT_W'(GAIN_CONV_CYC);
    assign conv_start = seq_reg == SEQ_SETUP && is_cal
        && cnt_reg == CNT_W'(SETUP_CYC - 1);
    // Divider stalls the FIFO; every other state pops it each cycle
    assign rd_if.ready = seq_reg != SEQ_DIV;
    assign off_store = seq_reg == SEQ_TAKE && rd_if.valid
        && mode_reg == MODE_OFF_CAL;
    assign gain_store = seq_reg == SEQ_DIV && mode_reg == MODE_GAIN_CAL
        && cnt_reg == CNT_W'(DIV_BITS - 1);
    assign conv_store = seq_reg == SEQ_IDLE && is_conv && rd_if.valid;

    // Restoring divide of 2^34 by the measured reference code
    always_comb begin
        div_trial = {rem_reg[WORD_W-1:0], cnt_reg == '0};
        div_ge = div_trial >= {1'b0, meas_reg};
        rem_next = div_ge ? div_trial - {1'b0, meas_reg} : div_trial;
        quo_next = {quo_reg[DIV_BITS-2:0], div_ge};
        if (meas_reg[WORD_W-1] || meas_reg == '0
            || quo_next[DIV_BITS-1:WORD_W] != '0) begin
            gain_next = '1;
        end else begin
            gain_next = quo_next[WORD_W-1:0];
        end
    end

    // set-up, conversion, division counted in cycles
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            seq_reg <= SEQ_IDLE;
            cnt_reg <= '0;
            meas_reg <= '0;
            rem_reg <= '0;
            quo_reg <= '0;
        end else if (seq_reg != SEQ_IDLE && !is_cal) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
            case (seq_reg)
                SEQ_IDLE: begin
                    cnt_reg <= '0;
                    if (is_cal) begin
                        seq_reg <= SEQ_SETUP;
                    end
                end
                SEQ_SETUP: begin
                    if (conv_start) begin
                        seq_reg <= SEQ_CONV;
                        cnt_reg <= '0;
                    end
                end
                SEQ_CONV: begin
                    if (cnt_reg == conv_target - 1'b1) begin
                        seq_reg <= SEQ_TAKE;
                    end
                end
                SEQ_TAKE: begin
                    cnt_reg <= '0;
                    rem_reg <= '0;
                    quo_reg <= '0;
                    if (rd_if.valid) begin
                        meas_reg <= rd_if.data;
                        seq_reg <= (mode_reg == MODE_OFF_CAL)
                            ? SEQ_IDLE : SEQ_DIV;
                    end
                end
                SEQ_DIV: begin
                    rem_reg <= rem_next;
                    quo_reg <= quo_next;
                    if (gain_store) begin
                        seq_reg <= SEQ_IDLE;
                    end
                end
                default: begin
                    seq_reg <= SEQ_IDLE;
                end
            endcase
        end
    end

    // host write, then idle when an offset or gain calibration completes
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            mode_reg <= MODE_IDLE;
            psel_reg <= CHSEL_RESET;
            nsel_reg <= CHSEL_RESET;
        end else if (wr_commit && addr_reg == ADDR_CTRL) begin
            mode_reg <= wr_word[CTRL_MODE_LSB+:4];
            psel_reg <= wr_word[CTRL_PSEL_LSB+:4];
            nsel_reg <= wr_word[CTRL_NSEL_LSB+:4];
        end else if (off_store || gain_store) begin
            mode_reg <= MODE_IDLE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            option_reg <= OPTION_RESET;
        end else if (wr_commit && addr_reg == ADDR_OPTION) begin
            option_reg <= wr_word[7:0];
        end
    end

    // Host writes take priority over calibration results
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            offset_reg <= OFFSET_RESET;
        end else if (wr_commit && addr_reg == ADDR_OFF_HI) begin
            offset_reg[23:16] <= wr_word[7:0];
        end else if (wr_commit && addr_reg == ADDR_OFF_LO) begin
            offset_reg[15:0] <= wr_word[15:0];
        end else if (off_store) begin
            offset_reg <= rd_if.data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            gain_reg <= GAIN_RESET;
        end else if (wr_commit && addr_reg == ADDR_GAIN_HI) begin
            gain_reg[23:16] <= wr_word[7:0];
        end else if (wr_commit && addr_reg == ADDR_GAIN_LO) begin
            gain_reg[15:0] <= wr_word[15:0];
        end else if (gain_store) begin
            gain_reg <= gain_next;
        end
    end

    always_comb begin
        if (mode_reg[MODE_CHOP_BIT]) begin
            diff = {rd_if.data[WORD_W-1], rd_if.data};
        end else begin
            diff = $signed({rd_if.data[WORD_W-1], rd_if.data})
                - $signed({offset_reg[WORD_W-1], offset_reg});
        end
        prod = diff * $signed({1'b0, gain_reg});
        scaled = prod >>> GAIN_SHIFT;
        ov_next = 1'b1;
        if (scaled > $signed({{(WORD_W+2){1'b0}}, RES_MAX})) begin
            result_next = RES_MAX;
        end else if (scaled < -$signed({{(WORD_W+2){1'b0}}, RES_MAX})
            - 1) begin
            result_next = RES_MIN;
        end else begin
            result_next = scaled[RES_W-1:0];
            ov_next = 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            result_reg <= '0;
            ov_reg <= 1'b0;
            rdy_cnt_reg <= 2'h0;
        end else if (conv_store) begin
            result_reg <= result_next;
            ov_reg <= ov_next;
            rdy_cnt_reg <= rdy_cnt_reg + 2'h1;
        end
    end

    // selects and reference drive the front end
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ready_low_reg <= 1'b0;
        end else if (off_store || gain_store || conv_store) begin
            ready_low_reg <= 1'b0;
        end else if (conv_start || (wr_commit && addr_reg == ADDR_CTRL
            && wr_word[CTRL_MODE_LSB+:4] != MODE_IDLE)) begin
            ready_low_reg <= 1'b1;
        end
    end

    assign o_pos_channel_select = psel_reg;
    assign o_neg_channel_select = nsel_reg;
    assign o_ref_int_en = option_reg[OPT_REF_BIT];
    assign o_first_amp_enable = option_reg[OPT_AMP1_BIT];
    assign o_second_amp_gain = option_reg[2:0];
    assign o_mode = mode_reg;
    assign o_conversion_ready_low = ready_low_reg;
    assign o_conversion_result = result_reg;

    // Checks
    logic [CNT_W-1:0] conv_len_reg;
    always_ff @(posedge i_mclk) begin
        if (i_srst || seq_reg != SEQ_CONV) begin
            conv_len_reg <= '0;
        end else begin
            conv_len_reg <= conv_len_reg + 1'b1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);

    // Framing clears one edge after select rises
    property p_pin_released;
        cs_high && $past(cs_high) |-> o_serial_out_ready_pin_oe_n
            && !busy_reg && bit_cnt_reg == 3'h0;
    endproperty
    a_pin_released: assert property (p_pin_released)
        else $error("Pin driven while deselected");

    property p_cmd_first;
        $fell(cs_high) |-> phase_reg == PH_CMD && bit_cnt_reg == 3'h0;
    endproperty
    a_cmd_first: assert property (p_cmd_first)
        else $error("Framing not reset by select");

    property p_idle_pin;
        !cs_high && !busy_reg |-> o_serial_out_ready_pin == ready_low_reg;
    endproperty
    a_idle_pin: assert property (p_idle_pin)
        else $error("Idle pin does not show ready flag");

    property p_off_store;
        off_store |=> offset_reg == $past(rd_if.data) && !ready_low_reg
            && mode_reg == MODE_IDLE;
    endproperty
    a_off_store: assert property (p_off_store)
        else $error("Offset calibration did not finish");

    property p_conv_len;
        seq_reg == SEQ_CONV ##1 seq_reg == SEQ_TAKE
            |-> $past(conv_len_reg) == conv_target - 1'b1;
    endproperty
    a_conv_len: assert property (p_conv_len)
        else $error("Calibration conversion length wrong");

    property p_rdy_rise;
        conv_start |=> ready_low_reg && seq_reg == SEQ_CONV;
    endproperty
    a_rdy_rise: assert property (p_rdy_rise)
        else $error("Ready flag not raised at conversion");

    property p_gain_done;
        gain_store |=> mode_reg == MODE_IDLE && seq_reg == SEQ_IDLE
            && !ready_low_reg;
    endproperty
    a_gain_done: assert property (p_gain_done)
        else $error("Gain calibration did not return idle");

    property p_result;
        conv_store |=> !ready_low_reg
            && rdy_cnt_reg == $past(rdy_cnt_reg) + 2'h1;
    endproperty
    a_result: assert property (p_result)
        else $error("Result store missed");

    c_off_cal: cover property (off_store);
    c_gain_cal: cover property (gain_store);
    c_read_done: cover property (byte_done && phase_reg == PH_DATA
        && rw_reg && left_reg == 2'h1);
    c_fifo_full: cover property (!wr_if.ready);
endmodule

// File: afs_pkg.sv
package afs_pkg;
    // Clock and timing
    localparam int CLK_PERIOD_NS = 20;
    localparam int SETUP_TIME_NS = 2000;
    localparam int ADC_PERIOD_NS = 1000;
    localparam int SETUP_CYC =
        (SETUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ADC_CYC =
        (ADC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFF_CONV_CYC = 3 * ADC_CYC;
    localparam int GAIN_CONV_CYC = 6 * ADC_CYC;
    // Divider walks one numerator bit per cycle
    localparam int DIV_BITS = 35;
    localparam int CNT_W = 16;
    // Data widths
    localparam int WORD_W = 24;
    localparam int RES_W = 16;
    localparam int FIFO_DEPTH = 8;
    localparam int GAIN_SHIFT = 19;
    // Mode codes
    localparam logic [3:0] MODE_IDLE = 4'h0;
    localparam logic [3:0] MODE_CONV_MAX = 4'h7;
    localparam logic [3:0] MODE_OFF_CAL = 4'hC;
    localparam logic [3:0] MODE_GAIN_CAL = 4'hD;
    localparam int MODE_CHOP_BIT = 2;
    // Register addresses
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_RESULT = 4'h1;
    localparam logic [3:0] ADDR_OPTION = 4'h6;
    localparam logic [3:0] ADDR_OFF_HI = 4'h7;
    localparam logic [3:0] ADDR_OFF_LO = 4'h8;
    localparam logic [3:0] ADDR_GAIN_HI = 4'h9;
    localparam logic [3:0] ADDR_GAIN_LO = 4'hA;
    // Command byte fields
    localparam int CMD_ADDR_LSB = 4;
    localparam int CMD_RW_BIT = 3;
    // Control word fields
    localparam int CTRL_MODE_LSB = 12;
    localparam int CTRL_PSEL_LSB = 8;
    localparam int CTRL_NSEL_LSB = 4;
    // Option register fields
    localparam int OPT_REF_BIT = 7;
    localparam int OPT_CE_BIT = 6;
    localparam int OPT_AMP1_BIT = 5;
    // Reset values
    localparam logic [WORD_W-1:0] GAIN_RESET = 24'h010000;
    localparam logic [WORD_W-1:0] OFFSET_RESET = 24'h000000;
    localparam logic [7:0] OPTION_RESET = 8'h00;
    localparam logic [3:0] CHSEL_RESET = 4'h0;
    localparam logic [15:0] RES_MAX = 16'h7FFF;
    localparam logic [15:0] RES_MIN = 16'h8000;

    typedef enum {SEQ_IDLE, SEQ_SETUP, SEQ_CONV, SEQ_TAKE, SEQ_DIV}
        afs_seq_type;
    typedef enum {PH_CMD, PH_DATA} afs_phase_type;

    // Data bytes that follow a command to this address
    function automatic logic [1:0] afs_reg_len(input logic [3:0] a);
        case (a)
            ADDR_CTRL, ADDR_RESULT, ADDR_OFF_LO, ADDR_GAIN_LO: begin
                return 2'h2;
            end
            default: begin
                return 2'h1;
            end
        endcase
    endfunction
endpackage

// File: afs_stream_if.sv
`timescale 1ns/100ps
interface afs_stream_if #(parameter int W = 24);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

// File: afs_fifo.sv
`timescale 1ns/100ps
module afs_fifo #(
    parameter int W = 24,
    parameter int DEPTH = 8
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    afs_stream_if.snk i_wr,
    afs_stream_if.src o_rd
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic full;
    logic empty;
    logic push;
    logic pop;

    // Extra pointer bit tells full from empty
    assign empty = wr_ptr_reg == rd_ptr_reg;
    assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW])
        && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
    assign push = i_wr.valid && !full;
    assign pop = o_rd.ready && !empty;
    assign i_wr.ready = !full;
    assign o_rd.valid = !empty;
    assign o_rd.data = mem[rd_ptr_reg[AW-1:0]];

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= i_wr.data;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

// File: afs_spi_master.sv
`timescale 1ns/100ps
module afs_spi_master (
    input wire logic i_mclk,
    input wire logic i_sdo,
    output logic o_sck,
    output logic o_sdi,
    output logic o_cs_n
);
    // Pins parked idle before reset ends
    task automatic park();
        o_sck <= 1'b0;
        o_sdi <= 1'b0;
        o_cs_n <= 1'b1;
    endtask
    // MSB first, data out on rise
    task automatic xb(input logic [7:0] tx, input int nb,
            output logic [7:0] rx);
        for (int i = 7; i > 7 - nb; i--) begin
            o_sck <= 1'b1;
            o_sdi <= tx[i];
            repeat (4) @(posedge i_mclk);
            o_sck <= 1'b0;
            @(posedge i_mclk);
            // Pin stands till next rise, so late sample is safe
            rx[i] = i_sdo;
            repeat (3) @(posedge i_mclk);
        end
    endtask
    task automatic cs(input logic v);
        o_cs_n <= v;
        repeat (4) @(posedge i_mclk);
    endtask
endmodule

// File: afs_spi_cal_tb_top.sv
`timescale 1ns/100ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fails++; \
$display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module afs_spi_cal_tb_top import afs_pkg::*;;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic sv = 1'b0;
    logic full_seen = 1'b0;
    logic [23:0] smp = '0;
    logic pin, oe_n, srdy, refi, amp1, rdyl;
    logic [3:0] psel, nsel, mode;
    logic [2:0] amp2g;
    logic [15:0] res, d;
    logic [7:0] st;
    wire sck, sdi, cs_n, sdo;
    int fails = 0;
    int n_tests = 0;
    int c;
    always #10 i_mclk = ~i_mclk;
    // Released pin has no pull, so show the inverse
    assign sdo = oe_n ? ~pin : pin;
    always @(posedge i_mclk) if (!srdy) full_seen <= 1'b1;
    afs_spi_master u_afs_spi_master (.i_mclk(i_mclk), .i_sdo(sdo),
        .o_sck(sck), .o_sdi(sdi), .o_cs_n(cs_n));
    afs_spi_cal u_afs_spi_cal (.i_mclk(i_mclk), .i_srst(i_srst),
        .i_sck(sck), .i_sdi(sdi), .i_chip_select_low_n(cs_n),
        .o_serial_out_ready_pin(pin), .o_serial_out_ready_pin_oe_n(oe_n),
        .i_sample_valid(sv), .i_sample(smp), .o_sample_ready(srdy),
        .o_pos_channel_select(psel), .o_neg_channel_select(nsel),
        .o_ref_int_en(refi), .o_first_amp_enable(amp1),
        .o_second_amp_gain(amp2g), .o_mode(mode),
        .o_conversion_ready_low(rdyl), .o_conversion_result(res));
    task automatic results();
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic acc(input logic [7:0] cmd, input int n,
            input logic [15:0] wd);
        logic [7:0] b;
        u_afs_spi_master.xb(cmd, 8, st);
        for (int j = n - 1; j >= 0; j--) begin
            u_afs_spi_master.xb(wd[j*8 +: 8], 8, b);
            d[j*8 +: 8] = b;
        end
    endtask
    task automatic fr(input logic [3:0] a, input logic r, input int n,
            input logic [15:0] wd);
        u_afs_spi_master.cs(1'b0);
        acc({a, r, 3'h0}, n, wd);
        u_afs_spi_master.cs(1'b1);
    endtask
    task automatic wfor(input logic rdy);
        for (c = 0; c < 3000; c++) begin
            @(posedge i_mclk);
            if ((rdy ? rdyl : (mode != 4'h0)) === 1'b0) return;
        end
        fails++;
        results();
    endtask
    initial begin
        u_afs_spi_master.park();
        repeat (20) @(posedge i_mclk);
        i_srst <= 1'b0;
        repeat (4) @(posedge i_mclk);
        `CHK(oe_n, 1'b1)
        fr(ADDR_GAIN_HI, 1'b1, 1, 16'h0);
        `CHK(d[7:0], GAIN_RESET[23:16])
        sv <= 1'b1;
        smp <= 24'h000123;
        fr(ADDR_OPTION, 1'b0, 1, 16'h0080);
        `CHK({refi, amp1, amp2g}, 5'h10)
        fr(ADDR_CTRL, 1'b0, 2, 16'hC770);
        `CHK(rdyl, 1'b1)
        `CHK({psel, nsel}, 8'h77)
        u_afs_spi_master.cs(1'b0);
        `CHK(pin, 1'b1)
        `CHK(oe_n, 1'b0)
        u_afs_spi_master.cs(1'b1);
        wfor(1'b0);
        `CHK(c > OFF_CONV_CYC, 1'b1)
        `CHK(rdyl, 1'b0)
        fr(ADDR_OFF_LO, 1'b1, 2, 16'h0);
        `CHK(d, 16'h0123)
        `CHK({st[7:4], st[1]}, 5'h00)
        smp <= 24'h020000;
        fr(ADDR_CTRL, 1'b0, 2, 16'hD670);
        wfor(1'b0);
        `CHK(c > GAIN_CONV_CYC, 1'b1)
        `CHK(full_seen, 1'b1)
        fr(ADDR_GAIN_HI, 1'b1, 1, 16'h0);
        `CHK(d[7:0], 8'h02)
        fr(ADDR_GAIN_LO, 1'b1, 2, 16'h0);
        `CHK(d, 16'h0000)
        `CHK(srdy, 1'b1)
        smp <= 24'h001123;
        fr(ADDR_CTRL, 1'b0, 2, 16'h1000);
        wfor(1'b1);
        `CHK(res, 16'h0400)
        fr(ADDR_RESULT, 1'b1, 2, 16'h0);
        `CHK(d, 16'h0400)
        fr(ADDR_CTRL, 1'b0, 2, 16'h5000);
        repeat (8) @(posedge i_mclk);
        `CHK(res, 16'h0448)
        fr(ADDR_CTRL, 1'b0, 2, 16'h0000);
        u_afs_spi_master.cs(1'b0);
        u_afs_spi_master.xb(8'h60, 8, st);
        u_afs_spi_master.xb(8'h55, 4, st);
        u_afs_spi_master.cs(1'b1);
        u_afs_spi_master.xb(8'h60, 8, st);
        u_afs_spi_master.xb(8'h55, 8, st);
        `CHK(oe_n, 1'b1)
        u_afs_spi_master.cs(1'b0);
        acc(8'h68, 1, 16'h0);
        `CHK(d[7:0], 8'h80)
        acc(8'h60, 1, 16'h0040);
        acc(8'h68, 1, 16'h0);
        `CHK(d[7:0], 8'h40)
        u_afs_spi_master.cs(1'b1);
        fr(ADDR_OPTION, 1'b0, 1, 16'h0000);
        fr(ADDR_CTRL, 1'b0, 2, 16'hC440);
        `CHK({psel, nsel, refi}, 9'h088)
        wfor(1'b0);
        fr(ADDR_OFF_HI, 1'b1, 1, 16'h0);
        `CHK(d[7:0], 8'h00)
        fr(ADDR_OFF_LO, 1'b1, 2, 16'h0);
        `CHK(d, 16'h1123)
        smp <= 24'h080000;
        fr(ADDR_CTRL, 1'b0, 2, 16'hD540);
        `CHK({psel, nsel}, 8'h54)
        wfor(1'b0);
        `CHK(rdyl, 1'b0)
        fr(ADDR_GAIN_HI, 1'b1, 1, 16'h0);
        `CHK(d[7:0], 8'h00)
        fr(ADDR_GAIN_LO, 1'b1, 2, 16'h0);
        `CHK(d, 16'h8000)
        results();
    end
endmodule
